// ===== hdl/fcl_pkg.sv
// constants and enums for the flash command and lock sequencer
package fcl_pkg;
    localparam int AW         = 11;
    localparam int DW         = 16;
    localparam int NBLK       = 4;
    localparam int BLK_W      = 2;
    localparam int BLK_LSB    = 9;
    localparam int PAGE_W     = 3;
    localparam int PAGE_LSB   = 8;
    localparam int WIDX_W     = 7;
    localparam int WORD_LSB   = 1;
    localparam int MIDX_W     = 10;
    localparam int PAGE_WORDS = 128;
    localparam int MEM_WORDS  = 1024;
    localparam int BLK_WORDS  = 256;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STAT  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STAT = 8'h50;
    localparam logic [7:0] CMD_PAGE_PROG  = 8'h41;
    localparam logic [7:0] CMD_BLK_ERASE  = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL  = 8'ha7;
    localparam logic [7:0] CMD_LOCK_PROG  = 8'h77;
    localparam logic [7:0] CMD_READ_LOCK  = 8'h71;
    localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
    localparam int ST_EW    = 3;
    localparam int ST_PE    = 4;
    localparam int ST_EE    = 5;
    localparam int ST_RDY   = 7;
    localparam int LOCK_BIT = 6;
    localparam logic [DW-1:0] ERASED     = 16'hffff;
    localparam logic [DW-1:0] DATA_ZERO  = 16'h0000;
    localparam logic [NBLK-1:0] LOCK_RST = 4'hf;
    localparam int CLK_NS     = 100;
    localparam int OP_TIME_NS = 1000;
    localparam int CNT_W      = 8;
    localparam logic [CNT_W-1:0] OP_CYCLES =
        CNT_W'((OP_TIME_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;
    localparam logic [WIDX_W-1:0] WCNT_LAST = 7'h7f;
    typedef enum logic [2:0] {
        M_ARRAY, M_STATUS, M_LOCK, M_PAGE,
        M_CONF_ERASE, M_CONF_ALL, M_CONF_LOCK, M_BUSY
    } fcl_mode_e;
    typedef enum logic [1:0] {
        OP_PROG, OP_ERASE, OP_ALL, OP_LOCK
    } fcl_op_e;
endpackage : fcl_pkg

// ===== hdl/fcl_sequencer.sv
// flash command decoder, lock bits and auto operation timer
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - one lock bit per block, 0 locks
// - lock cleared by program, set by erase
// - disable control bypasses locks, bits kept
// - disabled erase hits all, then unlocks
// - 16-bit even accesses, high byte ignored
// - FF selects read-array mode until changed
// - 70 makes next read return status
// - 50 clears three error bits
// - 41 then 128 words, then auto program
// - reprogramming gives no error, new data ANDed with old
// - 20 then D0 erases addressed block
// - A7 then D0 erases all unlocked
// - 77 then D0 locks addressed block
// - 71 then read gives lock on D6
// - ready flag marks completion, errors report
// - bad command sets erase and program errors
// - FF as confirm abandons to read-array
// - locked or failed erase sets erase error
// - locked or failed program sets program error
// - excessive write sets only its bit
// - no lock errors while locks disabled
// - ready low while busy, high after reset
// - commands only with rewrite mode enabled
module fcl_sequencer (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // bus port
    input  wire logic [fcl_pkg::AW-1:0]   addr,
    input  wire logic [fcl_pkg::DW-1:0]   wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [fcl_pkg::DW-1:0]   rdata,
    // controls
    input  wire logic                     rewrite_mode_enable,
    input  wire logic                     lock_disable_ctrl,
    input  wire logic                     op_fail_inject,
    input  wire logic                     excess_write_inject,
    // status
    output logic                          auto_op_ready_flag,
    output logic      [7:0]               status
);
    typedef struct packed {
        fcl_pkg::fcl_mode_e              mode;
        fcl_pkg::fcl_op_e                op;
        logic [fcl_pkg::BLK_W-1:0]       blk;
        logic [fcl_pkg::PAGE_W-1:0]      page;
        logic [fcl_pkg::WIDX_W-1:0]      wcnt;
        logic [fcl_pkg::CNT_W-1:0]       cnt;
        logic                            ew;
        logic                            pe;
        logic                            ee;
        logic                            rdy;
        logic [fcl_pkg::NBLK-1:0]        lock;
        logic [7:0]                      st;
        logic [fcl_pkg::DW-1:0]          rdata;
    } fcl_state_s;

    fcl_state_s s_r;
    fcl_state_s s_nxt;

    logic [fcl_pkg::DW-1:0] mem  [fcl_pkg::MEM_WORDS];
    logic [fcl_pkg::DW-1:0] pbuf [fcl_pkg::PAGE_WORDS];

    logic [7:0]                  cmd;
    logic [fcl_pkg::BLK_W-1:0]   wblk;
    logic [fcl_pkg::MIDX_W-1:0]  widx;
    logic                        idle;
    logic                        conf;
    logic                        fin;
    logic                        locked;
    logic                        do_prog;
    logic [fcl_pkg::NBLK-1:0]    erase_mask;
    logic [7:0]                  st_now;

    always_comb
    begin
        cmd    = wdata[7:0];
        wblk   = addr[fcl_pkg::BLK_LSB +: fcl_pkg::BLK_W];
        widx   = addr[fcl_pkg::WORD_LSB +: fcl_pkg::MIDX_W];
        idle   = (s_r.mode == fcl_pkg::M_ARRAY)
              || (s_r.mode == fcl_pkg::M_STATUS)
              || (s_r.mode == fcl_pkg::M_LOCK);
        conf   = (s_r.mode == fcl_pkg::M_CONF_ERASE)
              || (s_r.mode == fcl_pkg::M_CONF_ALL)
              || (s_r.mode == fcl_pkg::M_CONF_LOCK);
        fin    = (s_r.mode == fcl_pkg::M_BUSY)
              && (s_r.cnt == fcl_pkg::CNT_LAST);
        // a zero lock bit protects unless bypassed
        locked = !s_r.lock[s_r.blk] && !lock_disable_ctrl;
        st_now = 8'h00;
        st_now[fcl_pkg::ST_RDY] = s_r.rdy;
        st_now[fcl_pkg::ST_EE]  = s_r.ee;
        st_now[fcl_pkg::ST_PE]  = s_r.pe;
        st_now[fcl_pkg::ST_EW]  = s_r.ew;
    end

    always_comb
    begin
        s_nxt      = s_r;
        do_prog    = 1'b0;
        erase_mask = '0;
        s_nxt.st   = st_now;
        if (rd)
        begin
            unique case (s_r.mode)
                fcl_pkg::M_ARRAY:
                begin
                    s_nxt.rdata = mem[widx];
                end
                fcl_pkg::M_LOCK:
                begin
                    s_nxt.rdata = fcl_pkg::DATA_ZERO;
                    s_nxt.rdata[fcl_pkg::LOCK_BIT] = s_r.lock[wblk];
                end
                default:
                begin
                    s_nxt.rdata = {8'h00, st_now};
                end
            endcase
        end
        if (s_r.mode == fcl_pkg::M_BUSY)
        begin
            s_nxt.cnt = s_r.cnt - fcl_pkg::CNT_LAST;
        end
        else if (!rewrite_mode_enable)
        begin
            s_nxt.mode = fcl_pkg::M_ARRAY;
        end
        else if (wr && idle)
        begin
            s_nxt.blk = wblk;
            unique case (cmd)
                fcl_pkg::CMD_READ_ARRAY: s_nxt.mode = fcl_pkg::M_ARRAY;
                fcl_pkg::CMD_READ_STAT:  s_nxt.mode = fcl_pkg::M_STATUS;
                fcl_pkg::CMD_READ_LOCK:  s_nxt.mode = fcl_pkg::M_LOCK;
                fcl_pkg::CMD_CLEAR_STAT:
                begin
                    s_nxt.ew = 1'b0;
                    s_nxt.pe = 1'b0;
                    s_nxt.ee = 1'b0;
                end
                fcl_pkg::CMD_PAGE_PROG:
                begin
                    s_nxt.mode = fcl_pkg::M_PAGE;
                    s_nxt.wcnt = '0;
                end
                fcl_pkg::CMD_BLK_ERASE:  s_nxt.mode = fcl_pkg::M_CONF_ERASE;
                fcl_pkg::CMD_ERASE_ALL:  s_nxt.mode = fcl_pkg::M_CONF_ALL;
                fcl_pkg::CMD_LOCK_PROG:  s_nxt.mode = fcl_pkg::M_CONF_LOCK;
                default:
                begin
                    s_nxt.pe   = 1'b1;
                    s_nxt.ee   = 1'b1;
                    s_nxt.mode = fcl_pkg::M_STATUS;
                end
            endcase
        end
        else if (wr && s_r.mode == fcl_pkg::M_PAGE)
        begin
            // page comes from the first data word
            if (s_r.wcnt == '0)
            begin
                s_nxt.page = addr[fcl_pkg::PAGE_LSB +: fcl_pkg::PAGE_W];
                s_nxt.blk  = wblk;
            end
            s_nxt.wcnt = s_r.wcnt + 7'h01;
            if (s_r.wcnt == fcl_pkg::WCNT_LAST)
            begin
                s_nxt.mode = fcl_pkg::M_BUSY;
                s_nxt.op   = fcl_pkg::OP_PROG;
                s_nxt.cnt  = fcl_pkg::OP_CYCLES;
                s_nxt.rdy  = 1'b0;
            end
        end
        else if (wr && conf)
        begin
            if (cmd == fcl_pkg::CMD_CONFIRM)
            begin
                s_nxt.mode = fcl_pkg::M_BUSY;
                s_nxt.blk  = wblk;
                s_nxt.cnt  = fcl_pkg::OP_CYCLES;
                s_nxt.rdy  = 1'b0;
                if (s_r.mode == fcl_pkg::M_CONF_ERASE)
                begin
                    s_nxt.op = fcl_pkg::OP_ERASE;
                end
                else if (s_r.mode == fcl_pkg::M_CONF_ALL)
                begin
                    s_nxt.op = fcl_pkg::OP_ALL;
                end
                else
                begin
                    s_nxt.op = fcl_pkg::OP_LOCK;
                end
            end
            else if (cmd == fcl_pkg::CMD_READ_ARRAY)
            begin
                s_nxt.mode = fcl_pkg::M_ARRAY;
            end
            else
            begin
                s_nxt.pe   = 1'b1;
                s_nxt.ee   = 1'b1;
                s_nxt.mode = fcl_pkg::M_STATUS;
            end
        end
        if (fin)
        begin
            s_nxt.rdy  = 1'b1;
            s_nxt.mode = fcl_pkg::M_STATUS;
            unique case (s_r.op)
                fcl_pkg::OP_PROG:
                begin
                    if (locked || op_fail_inject)
                    begin
                        s_nxt.pe = 1'b1;
                    end
                    else if (excess_write_inject)
                    begin
                        s_nxt.ew = 1'b1;
                    end
                    else
                    begin
                        do_prog = 1'b1;
                    end
                end
                fcl_pkg::OP_ERASE:
                begin
                    if (locked || op_fail_inject)
                    begin
                        s_nxt.ee = 1'b1;
                    end
                    else
                    begin
                        erase_mask[s_r.blk] = 1'b1;
                        s_nxt.lock[s_r.blk] = 1'b1;
                    end
                end
                fcl_pkg::OP_ALL:
                begin
                    if (op_fail_inject)
                    begin
                        s_nxt.ee = 1'b1;
                    end
                    else
                    begin
                        // unless locks are disabled, locked blocks are skipped silently and stay locked
                        erase_mask = lock_disable_ctrl
                                   ? '1 : s_r.lock;
                        s_nxt.lock = s_r.lock | erase_mask;
                    end
                end
                fcl_pkg::OP_LOCK:
                begin
                    if (op_fail_inject)
                    begin
                        s_nxt.pe = 1'b1;
                    end
                    else
                    begin
                        s_nxt.lock[s_r.blk] = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r       <= '0;
            s_r.mode  <= fcl_pkg::M_ARRAY;
            s_r.rdy   <= 1'b1;
            s_r.lock  <= fcl_pkg::LOCK_RST;
            s_r.st[fcl_pkg::ST_RDY] <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // array cells only clear bits, so reprogramming ands old data
    always_ff @(posedge clk)
    begin
        if (wr && s_r.mode == fcl_pkg::M_PAGE && rewrite_mode_enable)
        begin
            pbuf[addr[fcl_pkg::WORD_LSB +: fcl_pkg::WIDX_W]] <= wdata;
        end
        for (int i = 0; i < fcl_pkg::MEM_WORDS; i++)
        begin
            if (erase_mask[i / fcl_pkg::BLK_WORDS])
            begin
                mem[i] <= fcl_pkg::ERASED;
            end
        end
        if (do_prog)
        begin
            for (int j = 0; j < fcl_pkg::PAGE_WORDS; j++)
            begin
                mem[{s_r.page, fcl_pkg::WIDX_W'(j)}] <=
                    mem[{s_r.page, fcl_pkg::WIDX_W'(j)}] & pbuf[j];
            end
        end
    end

    assign rdata              = s_r.rdata;
    assign auto_op_ready_flag = s_r.rdy;
    assign status             = s_r.st;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_busy_len;
        $fell(s_r.rdy) |-> ##10 s_r.rdy;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("ready not back after operation time");

    property p_clear;
        wr && idle && rewrite_mode_enable && cmd == fcl_pkg::CMD_CLEAR_STAT
        |=> !s_r.ew && !s_r.pe && !s_r.ee;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear status left an error bit");

    property p_seqerr;
        wr && conf && rewrite_mode_enable && cmd != fcl_pkg::CMD_CONFIRM
        && cmd != fcl_pkg::CMD_READ_ARRAY |=> s_r.pe && s_r.ee;
    endproperty
    a_seqerr: assert property (p_seqerr)
        else $error("bad confirm did not flag both errors");

    property p_abort;
        wr && conf && rewrite_mode_enable && cmd == fcl_pkg::CMD_READ_ARRAY
        |=> s_r.mode == fcl_pkg::M_ARRAY && s_r.rdy;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abandon did not return to read array");

    property p_stat_read;
        rd && s_r.mode == fcl_pkg::M_STATUS |=> rdata[7:0] == $past(st_now);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read returned wrong value");

    property p_lock_prog;
        fin && s_r.op == fcl_pkg::OP_LOCK && !op_fail_inject
        |=> !s_r.lock[$past(s_r.blk)] && s_r.rdy;
    endproperty
    a_lock_prog: assert property (p_lock_prog)
        else $error("lock bit not cleared");

    property p_all_unlock;
        fin && s_r.op == fcl_pkg::OP_ALL && !op_fail_inject
        |=> s_r.lock == ($past(s_r.lock) | {fcl_pkg::NBLK{$past(lock_disable_ctrl)}});
    endproperty
    a_all_unlock: assert property (p_all_unlock)
        else $error("erase all set wrong lock bits");

    property p_locked_prog;
        fin && s_r.op == fcl_pkg::OP_PROG && locked
        |=> s_r.pe && s_r.ee == $past(s_r.ee);
    endproperty
    a_locked_prog: assert property (p_locked_prog)
        else $error("program of locked block gave no error");

    property p_bypass;
        fin && lock_disable_ctrl && !op_fail_inject && !excess_write_inject
        |=> s_r.pe == $past(s_r.pe) && s_r.ee == $past(s_r.ee);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("error raised while locks disabled");

endmodule : fcl_sequencer

`default_nettype wire

// ===== tb/fcl_cpu_model.sv
// cpu bus master model issuing command and data cycles
`timescale 1ns/100ps
`default_nettype none
module fcl_cpu_model (
    // clock
    input  wire logic                   clk,
    // bus port
    output logic      [fcl_pkg::AW-1:0] addr,
    output logic      [fcl_pkg::DW-1:0] wdata,
    output logic                        wr,
    output logic                        rd,
    input  wire logic [fcl_pkg::DW-1:0] rdata,
    // completion
    input  wire logic                   rdy
);
    initial
    begin
        addr  = 11'h000;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // 16-bit access, bit0 forced low so every access is even
    task automatic wr_cyc(input logic [fcl_pkg::AW-1:0] a, input logic [fcl_pkg::DW-1:0] d);
        @(posedge clk);
        addr  <= a & 11'h7fe;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d; // released bus must not show the old word
    endtask : wr_cyc

    task automatic rd_cyc(input logic [fcl_pkg::AW-1:0] a, output logic [fcl_pkg::DW-1:0] q);
        @(posedge clk);
        addr <= a & 11'h7fe;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        q    = rdata;
    endtask : rd_cyc

    // command then 128 words, low address byte stepping 00..fe
    task automatic page_prog(input logic [fcl_pkg::AW-1:0] base, input logic [7:0] s);
        wr_cyc(base, 16'h0041);
        for (int i = 0; i < fcl_pkg::PAGE_WORDS; i++)
            wr_cyc(base | 11'(2 * i), {8'(i), s});
    endtask : page_prog

    // no access while busy, only the ready flag is polled
    task automatic wait_ready(output int n);
        n = 0;
        #1;
        while (rdy !== 1'b1 && n < 64)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_ready
endmodule : fcl_cpu_model
`default_nettype wire

// ===== tb/fcl_sequencer_tb_top.sv
// self-checking bench for the flash command and lock sequencer
`timescale 1ns/100ps
`default_nettype none
module fcl_sequencer_tb_top;
    logic                     clk;
    logic                     rst;
    logic [fcl_pkg::AW-1:0]   addr;
    logic [fcl_pkg::DW-1:0]   wdata;
    logic                     wr;
    logic                     rd;
    logic [fcl_pkg::DW-1:0]   rdata;
    logic                     rme;
    logic                     ldc;
    logic                     fail_inj;
    logic                     exw_inj;
    logic                     rdy;
    logic [7:0]               status;
    logic [fcl_pkg::DW-1:0]   q;
    int                       err_count = 0;
    int                       num_checks = 0;
    int                       n;

    fcl_sequencer uut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rewrite_mode_enable(rme), .lock_disable_ctrl(ldc), .op_fail_inject(fail_inj),
        .excess_write_inject(exw_inj), .auto_op_ready_flag(rdy), .status(status)
    );

    fcl_cpu_model cpu (
        .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rdy(rdy)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stat(input logic [7:0] e);
        cpu.wr_cyc(11'h000, 16'h0070);
        cpu.rd_cyc(11'h000, q);
        chk("status read", {8'h00, q[7:0]}, {8'h00, e});
        chk("status port", {8'h00, status}, {8'h00, e});
    endtask : stat

    task automatic clr();
        cpu.wr_cyc(11'h000, 16'h0050);
    endtask : clr

    // two-cycle command with confirm, then busy time
    task automatic op2(input logic [7:0] c, input logic [10:0] a, input int nb);
        cpu.wr_cyc(a, {8'h00, c});
        cpu.wr_cyc(a, {8'h00, fcl_pkg::CMD_CONFIRM});
        cpu.wait_ready(n);
        chk("busy cycles", 16'(n), 16'(nb));
    endtask : op2

    task automatic pp(input logic [10:0] base, input logic [7:0] s);
        cpu.page_prog(base, s);
        cpu.wait_ready(n);
        chk("prog busy cycles", 16'(n), 16'(fcl_pkg::OP_CYCLES));
    endtask : pp

    task automatic rdlock(input logic [10:0] a, input logic [15:0] e);
        cpu.wr_cyc(a, 16'h0071);
        cpu.rd_cyc(a, q);
        chk("lock bit", q, e);
    endtask : rdlock

    task automatic rdarr(input logic [10:0] a, input logic [15:0] e);
        cpu.wr_cyc(a, 16'h12ff);
        cpu.rd_cyc(a, q);
        chk("array word", q, e);
    endtask : rdarr

    initial
    begin
        repeat (30000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial
    begin
        rst = 1'b1;
        rme = 1'b1;
        ldc = 1'b0;
        fail_inj = 1'b0;
        exw_inj = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("ready after reset", {15'h0, rdy}, 16'h0001);
        stat(8'h80);
        op2(8'ha7, 11'h000, 10);
        stat(8'h80);
        rdarr(11'h7fe, 16'hffff);
        cpu.rd_cyc(11'h000, q);
        chk("array persists", q, 16'hffff);
        pp(11'h200, 8'h5a);
        rdarr(11'h200, 16'h005a);
        cpu.rd_cyc(11'h2fe, q);
        chk("last page word", q, 16'h7f5a);
        cpu.wr_cyc(11'h3fe, 16'h0020);
        cpu.wr_cyc(11'h3fe, 16'h00ff);
        cpu.rd_cyc(11'h200, q);
        chk("abandoned erase", q, 16'h005a);
        stat(8'h80);
        pp(11'h200, 8'ha5);
        stat(8'h80);
        op2(8'h77, 11'h3fe, 10);
        rdlock(11'h3fe, 16'h0000);
        rdlock(11'h1fe, 16'h0040);
        pp(11'h200, 8'h00);
        stat(8'h90);
        clr();
        stat(8'h80);
        op2(8'h20, 11'h3fe, 10);
        stat(8'ha0);
        clr();
        rdlock(11'h3fe, 16'h0000);
        @(posedge clk) ldc <= 1'b1;
        pp(11'h200, 8'h00);
        stat(8'h80);
        @(posedge clk) ldc <= 1'b0;
        op2(8'h20, 11'h3fe, 10);
        stat(8'ha0);
        clr();
        @(posedge clk) ldc <= 1'b1;
        op2(8'h20, 11'h3fe, 10);
        stat(8'h80);
        @(posedge clk) ldc <= 1'b0;
        rdlock(11'h3fe, 16'h0040);
        rdarr(11'h200, 16'hffff);
        pp(11'h200, 8'h3c);
        op2(8'h77, 11'h3fe, 10);
        op2(8'ha7, 11'h000, 10);
        stat(8'h80);
        rdarr(11'h200, 16'h003c);
        rdlock(11'h3fe, 16'h0000);
        @(posedge clk) ldc <= 1'b1;
        op2(8'ha7, 11'h000, 10);
        stat(8'h80);
        @(posedge clk) ldc <= 1'b0;
        rdlock(11'h3fe, 16'h0040);
        rdarr(11'h200, 16'hffff);
        cpu.wr_cyc(11'h000, 16'h0033);
        stat(8'hb0);
        clr();
        cpu.wr_cyc(11'h3fe, 16'h0020);
        cpu.wr_cyc(11'h3fe, 16'h0055);
        stat(8'hb0);
        clr();
        @(posedge clk) fail_inj <= 1'b1;
        op2(8'h20, 11'h5fe, 10);
        stat(8'ha0);
        clr();
        op2(8'h77, 11'h5fe, 10);
        stat(8'h90);
        clr();
        op2(8'ha7, 11'h000, 10);
        stat(8'ha0);
        clr();
        pp(11'h400, 8'h22);
        stat(8'h90);
        clr();
        @(posedge clk) fail_inj <= 1'b0;
        exw_inj <= 1'b1;
        pp(11'h600, 8'h11);
        stat(8'h88);
        clr();
        @(posedge clk) exw_inj <= 1'b0;
        rme <= 1'b0;
        cpu.wr_cyc(11'h7fe, 16'h0077);
        cpu.wr_cyc(11'h7fe, 16'h00d0);
        @(posedge clk) rme <= 1'b1;
        rdlock(11'h7fe, 16'h0040);
        stat(8'h80);
        close_out();
    end
endmodule : fcl_sequencer_tb_top
`default_nettype wire
